/* File: verif/siu_pin_partner.sv */
// Receive pins and channel operation clock enables.
// Assumes one clock; pins change only at its rising edge.
`timescale 1ns/1ps
module siu_pin_partner (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_slow,
    input  wire logic [3:0] i_rx_req,
    output logic      [3:0] o_rx_pin,
    output logic      [3:0] o_tick
);
    logic [1:0] div_q;
    // Pins reach the block as inputs, port direction set to input
    // Lines sit at pull-up level until released from reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q    <= 2'h0;
            o_rx_pin <= 4'hf;
        end else begin
            div_q    <= div_q + 2'h1;
            o_rx_pin <= i_rx_req;
        end
    end
    // Every cycle, or one in four to stress the sampling
    assign o_tick = {4{!i_slow || div_q == 2'h0}};
endmodule // siu_pin_partner

/* File: verif/siu_top_sva.sv */
// Assertions on the routing, filter and channel stop ports.
// Bound onto siu_top; sees only its ports.
`timescale 1ns/1ps
module siu_top_sva
    import siu_pkg::*;
(
    input wire logic [SIU_ADDR_W-1:0] i_addr,
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_wr,
    input wire logic [7:0]            i_wdata,
    input wire logic [3:0]            i_uart_rx_pin,
    input wire logic [3:0]            i_channel_op_clock,
    input wire logic                  i_slave_select_pin,
    input wire logic                  i_spi_zero_slave,
    input wire logic [3:0]            o_rx_level,
    input wire logic                  o_ext_irq_zero,
    input wire logic                  o_timer_ch7_in,
    input wire logic                  o_spi_zero_sck,
    input wire logic [1:0]            o_unit_clk_en,
    input wire logic [7:0]            o_ch_enable_status,
    input wire logic [7:0]            o_clock_out_level
);
    logic [7:0] isc_q;
    logic [7:0] nfen_q;
    logic [7:0] per_q;
    wire        st_wr = i_wr && (i_addr == SIU_ST0_ADDR);
    ////////////////////////////////////////
    // Shadow bytes; routing judged only once settled
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            isc_q  <= SIU_ISC_RST;
            nfen_q <= SIU_NFEN_RST;
            per_q  <= SIU_PER_RST;
        end else begin
            isc_q  <= (i_wr && i_addr == SIU_ISC_ADDR) ? i_wdata : isc_q;
            nfen_q <= (i_wr && i_addr == SIU_NFEN_ADDR) ? i_wdata : nfen_q;
            per_q  <= (i_wr && i_addr == SIU_PER_ADDR) ? i_wdata : per_q;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    property p_stop;
        st_wr && per_q[SIU_PER_U0_BIT] |-> ##2 (o_ch_enable_status[3:0] & $past(i_wdata[3:0], 2)) == 4'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped channel still enabled");
    property p_fall;
        ($past(o_ch_enable_status[3:0]) & ~o_ch_enable_status[3:0]) != 4'h0 |-> $past(st_wr, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("status dropped without stop");
    property p_per;
        i_wr && i_addr == SIU_PER_ADDR |-> ##2 o_unit_clk_en == $past(i_wdata[3:2], 2);
    endproperty
    a_per: assert property (p_per) else $error("unit clock enables wrong");
    property p_cko;
        (o_ch_enable_status[3:0] == 4'hf) [*3] |-> $stable(o_clock_out_level[3:0]);
    endproperty
    a_cko: assert property (p_cko) else $error("clock level moved while running");
    property p_route;
        (isc_q[1:0] == 2'h3 && $stable(o_rx_level[0])) [*3] |-> {o_ext_irq_zero, o_timer_ch7_in} == {2{o_rx_level[0]}};
    endproperty
    a_route: assert property (p_route) else $error("receive pin not routed");
    property p_ssi;
        (isc_q[SIU_ISC_SSI_BIT] && i_spi_zero_slave && i_slave_select_pin) [*4] |-> o_spi_zero_sck;
    endproperty
    a_ssi: assert property (p_ssi) else $error("clock passed while deselected");
    property p_filt;
        (!nfen_q[0] && i_channel_op_clock[0] && $stable(i_uart_rx_pin[0])) [*6] |-> o_rx_level[0] == i_uart_rx_pin[0];
    endproperty
    a_filt: assert property (p_filt) else $error("unfiltered level wrong");
    property p_nf;
        (nfen_q[4] && i_channel_op_clock[2] && $stable(i_uart_rx_pin[2])) [*8] |-> o_rx_level[2] == i_uart_rx_pin[2];
    endproperty
    a_nf: assert property (p_nf) else $error("filtered level wrong");
endmodule // siu_top_sva

bind siu_top siu_top_sva u_sva (.*);

/* File: verif/siu_top_tb.sv */
// Self-checking bench for the serial unit routing block.
// Assumes siu_top, the pin partner and the checker compiled first.
`timescale 1ns/1ps
module siu_top_tb
    import siu_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [19:0] addr = 20'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, slow = 1'b0, slave = 1'b0;
    logic        ext_pin = 1'b0, tmr_pin = 1'b0, ssi_pin = 1'b1, sck_pin = 1'b1;
    logic [3:0]  rx_req = 4'hf, low, rxl, rx_pin, tick;
    logic [7:0]  rdata, status, dlev, clev, exp_q[$];
    logic [1:0]  uclk, uact;
    logic        irq, tmr, sck, rd_p1 = 1'b0, rd_p2 = 1'b0;
    int          error_cnt = 0, checks_done = 0, seed = 57, cyc = 0;

    always #2.5 i_clk = ~i_clk;

    siu_top uut (.i_clk(i_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .i_uart_rx_pin(rx_pin), .i_channel_op_clock(tick),
        .i_ext_irq_zero_pin(ext_pin), .i_timer_ch7_pin(tmr_pin), .i_slave_select_pin(ssi_pin),
        .i_spi_zero_sck_pin(sck_pin), .i_spi_zero_slave(slave), .o_rx_level(rxl),
        .o_ext_irq_zero(irq), .o_timer_ch7_in(tmr), .o_spi_zero_sck(sck), .o_unit_clk_en(uclk),
        .o_unit_active(uact), .o_ch_enable_status(status), .o_data_out_level(dlev),
        .o_clock_out_level(clev));
    siu_pin_partner u_pins (.i_clk(i_clk), .i_rst_b(rst_b), .i_slow(slow), .i_rx_req(rx_req),
        .o_rx_pin(rx_pin), .o_tick(tick));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One-cycle strobes, held up to the sampling edge
    task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
        @(posedge i_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
        @(posedge i_clk);
        rd   <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk);
        rd <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Read data lands one cycle after the strobe; also bounds the run
    always @(posedge i_clk) begin
        rd_p1 <= rd;
        rd_p2 <= rd_p1;
        cyc   <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    always @(negedge i_clk) begin
        if (rd_p2) chk(rdata, exp_q.pop_front());
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0] v;
        wt(20);
        rst_b <= 1'b1;
        wt(2);
        chk({rxl, 2'h0, uclk}, 8'hf0);
        rd_chk(SIU_NFEN_ADDR, 8'h00);
        rd_chk(SIU_NFEN_ADDR + 20'h1, 8'h00);
        // Unit 0 unclocked: writes lost, defaults read
        wr_reg(SIU_SS0_ADDR, 8'h01);
        wr_reg(SIU_SO0_ADDR, 8'h00);
        rd_chk(SIU_SO0_ADDR, 8'h0f);
        chk(status, 8'h00);
        chk(dlev & clev, 8'hff);
        wr_reg(SIU_PER_ADDR, 8'h04);
        wt(2);
        chk(uclk, 8'h01);
        wr_reg(SIU_PER_ADDR, 8'h0c);
        wt(2);
        chk(uclk, 8'h03);
        // Start, poke read-only status, then stop half
        wr_reg(SIU_SS0_ADDR, 8'h0f);
        wr_reg(SIU_SS0_ADDR + SIU_UNIT_STRIDE, 8'h03);
        wr_reg(SIU_SE0_ADDR, 8'h00);
        wr_reg(SIU_SO0_ADDR + 20'h1, 8'h00);
        wr_reg(SIU_SO0_ADDR, 8'h05);
        wt(2);
        chk(status, 8'h3f);
        chk(clev, 8'hff);
        chk(dlev, 8'hf5);
        chk(uact, 8'h03);
        wr_reg(SIU_ST0_ADDR, 8'h05);
        rd_chk(SIU_ST0_ADDR, 8'h00);
        rd_chk(SIU_SE0_ADDR, 8'h0a);
        rd_chk(SIU_SE0_ADDR + SIU_UNIT_STRIDE, 8'h03);
        wr_reg(SIU_SO0_ADDR + 20'h1, 8'h00);
        wt(2);
        chk(clev, 8'hfa);
        // Routing and filter bytes, reserved bits kept clear
        repeat (3) begin
            v = 8'($random(seed));
            wr_reg(SIU_ISC_ADDR, v & 8'h83);
            wr_reg(SIU_NFEN_ADDR, v & 8'h55);
            rd_chk(SIU_ISC_ADDR, v & 8'h83);
            rd_chk(SIU_NFEN_ADDR, v & 8'h55);
        end
        wr_reg(SIU_NFEN_ADDR, 8'h00);
        repeat (4) begin
            v = 8'($random(seed));
            wr_reg(SIU_ISC_ADDR, 8'h03);
            rx_req  <= {3'h7, v[0]};
            ext_pin <= !v[0];
            tmr_pin <= !v[0];
            wt(8);
            chk({irq, tmr}, {2{v[0]}});
            wr_reg(SIU_ISC_ADDR, 8'h00);
            wt(8);
            chk({irq, tmr}, {2{!v[0]}});
        end
        // One-cycle glitch: filtered inputs hold, others pass it
        for (int i = 0; i < 2; i++) begin
            wr_reg(SIU_NFEN_ADDR, i ? 8'h54 : 8'h01);
            rx_req <= 4'hf;
            wt(8);
            low = 4'hf;
            rx_req <= 4'h0;
            @(posedge i_clk);
            rx_req <= 4'hf;
            repeat (10) begin
                @(negedge i_clk);
                low = low & rxl;
            end
            chk(low, i ? 8'h0e : 8'h01);
        end
        slow   <= 1'b1;
        rx_req <= 4'h0;
        wt(24);
        chk(rxl, 8'h00);
        // Slave select gates the channel-0 serial clock
        wr_reg(SIU_SS0_ADDR, 8'h01);
        wr_reg(SIU_ISC_ADDR, 8'h80);
        slave   <= 1'b1;
        sck_pin <= 1'b0;
        wt(6);
        chk(sck, 8'h01);
        ssi_pin <= 1'b0;
        wt(6);
        chk(sck, 8'h00);
        ssi_pin <= 1'b1;
        wr_reg(SIU_ISC_ADDR, 8'h00);
        wt(6);
        chk(sck, 8'h00);
        // Stop unit 0, then cut both unit clocks
        wr_reg(SIU_ST0_ADDR, 8'h0f);
        // Port use: both level bytes back to ones on the stopped unit
        wr_reg(SIU_SO0_ADDR, 8'h0f);
        wr_reg(SIU_SO0_ADDR + 20'h1, 8'h0f);
        wr_reg(SIU_PER_ADDR, 8'h00);
        wt(4);
        chk({uact, 3'h0, sck}, 8'h01);
        chk(dlev, 8'hff);
        chk(clev, 8'hff);
        rd_chk(SIU_SO0_ADDR + 20'h1, 8'h0f);
        wt(4);
        close_out();
    end
endmodule // siu_top_tb

/* File: verilog/siu_chan_ctrl.sv */
// Channel start/stop, enable status and output level bits of one unit.
// Assumes the write strobes are single-cycle and already address-decoded.
`timescale 1ns/1ps
module siu_chan_ctrl
    import siu_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_unit_en,
    input  wire logic       i_ss_wr,
    input  wire logic       i_st_wr,
    input  wire logic       i_so_lo_wr,
    input  wire logic       i_so_hi_wr,
    input  wire logic [7:0] i_wdata,
    output logic      [3:0] o_se,
    output logic      [3:0] o_so,
    output logic      [3:0] o_cko
);
    logic [3:0] se_q;
    logic [3:0] se_d;
    logic [3:0] so_q;
    logic [3:0] cko_q;
    logic [3:0] cko_d;
    logic       wr_ok;

    // Unit without clock takes no writes
    assign wr_ok = i_unit_en;

    // Stop trigger clears status; it is never stored, so reads as zero
    assign se_d  = (se_q | ({4{i_ss_wr & wr_ok}} & i_wdata[3:0]))
                   & ~({4{i_st_wr & wr_ok}} & i_wdata[3:0]);

    // Clock level bits move only on stopped channels
    assign cko_d = (cko_q & se_q) | (i_wdata[3:0] & ~se_q);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            se_q  <= SIU_SE_RST;
            so_q  <= SIU_SO_RST;
            cko_q <= SIU_CKO_RST;
        end else begin
            se_q <= se_d;
            if (i_so_lo_wr && wr_ok) begin
                so_q <= i_wdata[3:0];
            end
            if (i_so_hi_wr && wr_ok) begin
                cko_q <= cko_d;
            end
        end
    end

    assign o_se  = se_q;
    assign o_so  = so_q;
    assign o_cko = cko_q;
endmodule // siu_chan_ctrl

/* File: verilog/siu_pkg.sv */
// Constants for the serial unit input routing and stop control block.
// Assumes a byte-wide register port with a 20-bit address space.
package siu_pkg;
    localparam int          SIU_ADDR_W      = 20;
    localparam int          SIU_UNITS       = 2;
    localparam int          SIU_CHANS       = 4;
    localparam int          SIU_RX_PINS     = 4;

    // Register byte addresses
    localparam logic [19:0] SIU_NFEN_ADDR   = 20'hf0070;
    localparam logic [19:0] SIU_ISC_ADDR    = 20'hf0073;
    localparam logic [19:0] SIU_PER_ADDR    = 20'hf00f0;
    localparam logic [19:0] SIU_SE0_ADDR    = 20'hf0120;
    localparam logic [19:0] SIU_SS0_ADDR    = 20'hf0122;
    localparam logic [19:0] SIU_ST0_ADDR    = 20'hf0124;
    localparam logic [19:0] SIU_SO0_ADDR    = 20'hf0128;
    localparam logic [19:0] SIU_UNIT_STRIDE = 20'h00040;

    // Field positions
    localparam int          SIU_ISC_IRQ_BIT = 0;
    localparam int          SIU_ISC_TMR_BIT = 1;
    localparam int          SIU_ISC_SSI_BIT = 7;
    localparam int          SIU_PER_U0_BIT  = 2;
    localparam int          SIU_NFEN_STEP   = 2;

    // Reset values
    localparam logic [7:0]  SIU_NFEN_RST    = 8'h00;
    localparam logic [7:0]  SIU_ISC_RST     = 8'h00;
    localparam logic [7:0]  SIU_PER_RST     = 8'h00;
    localparam logic [3:0]  SIU_SE_RST      = 4'h0;
    localparam logic [3:0]  SIU_SO_RST      = 4'hf;
    localparam logic [3:0]  SIU_CKO_RST     = 4'hf;
endpackage

/* File: verilog/siu_rx_filter.sv */
// One receive input: two-flop synchroniser, then optional two-sample match.
// Assumes i_tick is a one-cycle enable at the channel operation clock rate.
`timescale 1ns/1ps
module siu_rx_filter (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    input  wire logic i_tick,
    input  wire logic i_en,
    output logic      o_level
);
    logic meta_q;
    logic sync_q;
    logic smp_q;
    logic lvl_q;
    logic lvl_d;

    // Pin is asynchronous; meta_q feeds only sync_q
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    // Filter off passes the synced level; on, two agreeing samples needed
    assign lvl_d = !i_en ? sync_q :
                   (sync_q == smp_q) ? sync_q :
                   lvl_q;

    // Idle line is high, so reset to 1 avoids a false start bit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            smp_q <= 1'b1;
            lvl_q <= 1'b1;
        end else if (i_tick) begin
            smp_q <= sync_q;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule // siu_rx_filter

/* File: verilog/siu_top.sv */
// Serial unit input routing, receive filters, unit clock gating, channel stop.
// Assumes a single-cycle byte register port on i_clk and async pins.
// Unit control registers follow the peripheral enable bits; global bytes do not.
`timescale 1ns/1ps
module siu_top
    import siu_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    // Register port
    input  wire logic [SIU_ADDR_W-1:0] i_addr,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic [7:0]            i_wdata,
    output logic      [7:0]            o_rdata,
    // Pins and channel clocks
    input  wire logic [3:0]            i_uart_rx_pin,
    input  wire logic [3:0]            i_channel_op_clock,
    input  wire logic                  i_ext_irq_zero_pin,
    input  wire logic                  i_timer_ch7_pin,
    input  wire logic                  i_slave_select_pin,
    input  wire logic                  i_spi_zero_sck_pin,
    input  wire logic                  i_spi_zero_slave,
    // Routed and qualified signals
    output logic [3:0]                 o_rx_level,
    output logic                       o_ext_irq_zero,
    output logic                       o_timer_ch7_in,
    output logic                       o_spi_zero_sck,
    output logic [1:0]                 o_unit_clk_en,
    output logic [1:0]                 o_unit_active,
    output logic [7:0]                 o_ch_enable_status,
    output logic [7:0]                 o_data_out_level,
    output logic [7:0]                 o_clock_out_level
);
    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Per-unit address of a register, unit stride applied
    function automatic logic [19:0] unit_addr(input logic [19:0] base, input int unit);
        unit_addr = (unit == 0) ? base : base + SIU_UNIT_STRIDE;
    endfunction

    // Filter enable bit position of a receive pin
    function automatic int nf_bit(input int pin);
        nf_bit = pin * SIU_NFEN_STEP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Global registers

    logic [7:0] nfen_q;
    logic [7:0] isc_q;
    logic [7:0] per_q;
    logic       wr_nfen;
    logic       wr_isc;
    logic       wr_per;

    // Global register write strobes, exempt from unit gating
    assign wr_nfen = i_wr && (i_addr == SIU_NFEN_ADDR);
    assign wr_isc  = i_wr && (i_addr == SIU_ISC_ADDR);
    assign wr_per  = i_wr && (i_addr == SIU_PER_ADDR);

    // Filter enables; reserved bits are software's to keep zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            nfen_q <= SIU_NFEN_RST;
        end else if (wr_nfen) begin
            nfen_q <= i_wdata;
        end
    end

    // Input switch byte, stored as written
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            isc_q <= SIU_ISC_RST;
        end else if (wr_isc) begin
            isc_q <= i_wdata;
        end
    end

    // Peripheral enable byte; never gated itself, or units could not restart
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            per_q <= SIU_PER_RST;
        end else if (wr_per) begin
            per_q <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive filters

    logic [3:0] rx_filt;

    generate
        for (genvar p = 0; p < SIU_RX_PINS; p++) begin : g_rx
            siu_rx_filter u_filt (
                .i_clk   (i_clk),
                .i_rst_b (i_rst_b),
                .i_pin   (i_uart_rx_pin[p]),
                .i_tick  (i_channel_op_clock[p]),
                .i_en    (nfen_q[nf_bit(p)]),
                .o_level (rx_filt[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Channel control per unit

    logic [1:0] unit_en;
    logic [3:0] se   [2];
    logic [3:0] so   [2];
    logic [3:0] cko  [2];
    logic [7:0] unit_rd [2];

    // Unit clock enables straight from the peripheral enable bits
    assign unit_en = per_q[SIU_PER_U0_BIT +: 2];

    generate
        for (genvar u = 0; u < SIU_UNITS; u++) begin : g_unit
            logic a_se;
            logic a_ss;
            logic a_st;
            logic a_lo;
            logic a_hi;

            assign a_se = (i_addr == unit_addr(SIU_SE0_ADDR, u));
            assign a_ss = (i_addr == unit_addr(SIU_SS0_ADDR, u));
            assign a_st = (i_addr == unit_addr(SIU_ST0_ADDR, u));
            assign a_lo = (i_addr == unit_addr(SIU_SO0_ADDR, u));
            assign a_hi = (i_addr == unit_addr(SIU_SO0_ADDR, u) + 20'h00001);

            siu_chan_ctrl u_ctrl (
                .i_clk      (i_clk),
                .i_rst_b    (i_rst_b),
                .i_unit_en  (unit_en[u]),
                .i_ss_wr    (i_wr && a_ss),
                .i_st_wr    (i_wr && a_st),
                .i_so_lo_wr (i_wr && a_lo),
                .i_so_hi_wr (i_wr && a_hi),
                .i_wdata    (i_wdata),
                .o_se       (se[u]),
                .o_so       (so[u]),
                .o_cko      (cko[u])
            );

            // Gated unit reads its defaults; trigger registers read zero
            assign unit_rd[u] = !unit_en[u] ?
                                    (a_lo ? {4'h0, SIU_SO_RST} :
                                     a_hi ? {4'h0, SIU_CKO_RST} : 8'h00) :
                                a_se ? {4'h0, se[u]} :
                                a_lo ? {4'h0, so[u]} :
                                a_hi ? {4'h0, cko[u]} : 8'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [7:0] rdata_d;

    // Unmapped addresses read zero
    assign rdata_d = (i_addr == SIU_NFEN_ADDR) ? nfen_q :
                     (i_addr == SIU_ISC_ADDR)  ? isc_q  :
                     (i_addr == SIU_PER_ADDR)  ? per_q  :
                     (unit_rd[0] | unit_rd[1]);

    ////////////////////////////////////////////////////////////////////////////
    // Slave select, serial clock, interrupt and timer pins

    logic ssi_meta_q;
    logic ssi_q;
    logic sck_meta_q;
    logic sck_q;
    logic irq_meta_q;
    logic irq_q;
    logic tmr_meta_q;
    logic tmr_q;

    // Slave select synchroniser; resets deselected
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ssi_meta_q <= 1'b1;
            ssi_q      <= 1'b1;
        end else begin
            ssi_meta_q <= i_slave_select_pin;
            ssi_q      <= ssi_meta_q;
        end
    end

    // Serial clock synchroniser; resets at idle high
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_meta_q <= 1'b1;
            sck_q      <= 1'b1;
        end else begin
            sck_meta_q <= i_spi_zero_sck_pin;
            sck_q      <= sck_meta_q;
        end
    end

    // Dedicated interrupt pin synchroniser
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_meta_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            irq_meta_q <= i_ext_irq_zero_pin;
            irq_q      <= irq_meta_q;
        end
    end

    // Normal timer pin synchroniser
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tmr_meta_q <= 1'b0;
            tmr_q      <= 1'b0;
        end else begin
            tmr_meta_q <= i_timer_ch7_pin;
            tmr_q      <= tmr_meta_q;
        end
    end

    logic sck_block;
    logic sck_d;
    logic irq_d;
    logic tmr_d;
    logic [1:0] active_d;

    // Deselected slave holds clock at idle so no bit is shifted
    assign sck_block = isc_q[SIU_ISC_SSI_BIT] && i_spi_zero_slave && ssi_q;
    // Stopped unit or channel passes no serial clock
    assign sck_d     = (sck_block || !unit_en[0] || !se[0][0]) ? 1'b1 : sck_q;

    // Receive pin 0 routing for wakeup and break measurement
    assign irq_d = isc_q[SIU_ISC_IRQ_BIT] ? rx_filt[0] : irq_q;
    assign tmr_d = isc_q[SIU_ISC_TMR_BIT] ? rx_filt[0] : tmr_q;

    // Unit owns its pins only while clocked with a channel enabled
    assign active_d = {unit_en[1] && (|se[1]), unit_en[0] && (|se[0])};

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    // Read data holds until the next read strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end
    end

    // Routed pin levels, reset to their idle levels
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_level     <= 4'hf;
            o_ext_irq_zero <= 1'b0;
            o_timer_ch7_in <= 1'b0;
            o_spi_zero_sck <= 1'b1;
        end else begin
            o_rx_level     <= rx_filt;
            o_ext_irq_zero <= irq_d;
            o_timer_ch7_in <= tmr_d;
            o_spi_zero_sck <= sck_d;
        end
    end

    // Unit and channel state; levels reset high so pins idle as port pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_unit_clk_en      <= 2'h0;
            o_unit_active      <= 2'h0;
            o_ch_enable_status <= 8'h00;
            o_data_out_level   <= 8'hff;
            o_clock_out_level  <= 8'hff;
        end else begin
            o_unit_clk_en      <= unit_en;
            o_unit_active      <= active_d;
            o_ch_enable_status <= {se[1], se[0]};
            o_data_out_level   <= {so[1], so[0]};
            o_clock_out_level  <= {cko[1], cko[0]};
        end
    end
endmodule // siu_top
